//--- logic/burst_address.sv
// Burst beat address: linear or interleaved order on the low address bits.
// Pure combinational; the caller holds the loaded base and beat count.
module burst_address
	import sram_port_pkg::*;
(
	input  wire logic                  i_order,
	input  wire logic [BURST_BITS-1:0] i_base,
	input  wire logic [BURST_BITS-1:0] i_beat,
	output logic      [BURST_BITS-1:0] o_low
);
	always_comb begin
		if (i_order == BURST_INTERLEAVED) begin
			o_low = i_base ^ i_beat;
		end else begin
			o_low = i_base + i_beat;
		end
	end
endmodule

//--- logic/sram_array.sv
// Memory array with per-lane write masks and registered read data.
// Assumes the caller presents one access per clock at most.
module sram_array
	import sram_port_pkg::*;
#(
	parameter int ADDR_WIDTH = ADDR_WIDTH_DEFAULT,
	parameter int LANES      = LANES_DEFAULT,
	parameter int LANE_WIDTH = LANE_WIDTH_DEFAULT
) (
	input  wire logic                        i_clock,
	input  wire logic                        i_read,
	input  wire logic                        i_write,
	input  wire logic [ADDR_WIDTH-1:0]       i_address,
	input  wire logic [LANES-1:0]            i_lane_write,
	input  wire logic [LANES*LANE_WIDTH-1:0] i_write_data,
	output logic      [LANES*LANE_WIDTH-1:0] o_read_data
);
	logic [LANES*LANE_WIDTH-1:0] memory [0:(1<<ADDR_WIDTH)-1];

	always_ff @(posedge i_clock) begin
		if (i_read) begin
			o_read_data <= memory[i_address];
		end
	end

	for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
		always_ff @(posedge i_clock) begin
			if (i_write && i_lane_write[lane]) begin
				memory[i_address][lane*LANE_WIDTH +: LANE_WIDTH] <=
					i_write_data[lane*LANE_WIDTH +: LANE_WIDTH];
			end
		end
	end
endmodule

//--- logic/sram_port.sv
// Synchronous host port of a pipelined zero-turnaround static memory.
// Assumes all pins synchronous to i_clock except i_rstn and i_output_drive_enable_n.
//
// Functional notes
// - Address captured only on load, clock gate low, all selects true.
// - Load low with chip selected starts a new access.
// - Load low while deselected ends any burst in progress.
// - Advance high steps the burst counter of a running burst.
// - Address lines ignored whenever advance is sampled high.
// - Read or write data moves two cycles after its cycle.
// - Clock gate high freezes all registers and the data outputs, not the drive enable gating.
// - Byte selects ignored when read is sampled.
// - Only selected lanes written, data taken two cycles later.
// - Any chip select false with load low starts a deselect.
// - Data lines float two cycles after a deselect.
// - High select acts like the low selects, inverted polarity.
// - Everything on rising edge except reset and output drive enable.
// - Write and read data both registered on the clock.
// - Burst order interleaved when order select high, else linear.
// - Output drive enable high floats data lines at once.
// - Four beats per loaded address through the burst counter.
// - Pending transfers finish after a deselect.
// - Data lines released two cycles after a write starts.
module sram_port
	import sram_port_pkg::*;
#(
	parameter int ADDR_WIDTH = ADDR_WIDTH_DEFAULT,
	parameter int LANES      = LANES_DEFAULT,
	parameter int LANE_WIDTH = LANE_WIDTH_DEFAULT
) (
	input  wire logic                        i_clock,
	input  wire logic                        i_rstn,
	input  wire logic [ADDR_WIDTH-1:0]       i_address_lines,
	input  wire logic                        i_advance_or_load,
	input  wire logic                        i_read_not_write,
	input  wire logic                        i_clock_gate_n,
	input  wire logic [LANES-1:0]            i_byte_write_selects_n,
	input  wire logic                        i_chip_select_low_1_n,
	input  wire logic                        i_chip_select_low_2_n,
	input  wire logic                        i_chip_select_high,
	input  wire logic                        i_burst_order_select,
	input  wire logic                        i_output_drive_enable_n,
	input  wire logic [LANES*LANE_WIDTH-1:0] i_data_lines,
	output logic      [LANES*LANE_WIDTH-1:0] o_data_lines,
	output logic                             o_data_lines_oe
);
	localparam int DATA_WIDTH = LANES * LANE_WIDTH;

	typedef struct packed {
		logic [ADDR_WIDTH-1:0] base;
		logic [BURST_BITS-1:0] beat;
		logic                  burst_live;
		access_type            burst_kind;
		access_type            stage1_kind;
		logic [ADDR_WIDTH-1:0] stage1_addr;
		logic [LANES-1:0]      stage1_lanes;
		access_type            stage2_kind;
		logic [ADDR_WIDTH-1:0] stage2_addr;
		logic [LANES-1:0]      stage2_lanes;
		logic                  drive;
	} state_type;

	state_type state;
	state_type next_state;

	////////////////////////////////////////////////////////////////////////////////
	// Cycle decode

	logic                  selected;
	logic                  load;
	logic                  advance;
	logic [BURST_BITS-1:0] next_beat;
	logic [BURST_BITS-1:0] beat_low;
	logic [ADDR_WIDTH-1:0] beat_addr;
	logic [ADDR_WIDTH-1:0] load_addr;
	logic [LANES-1:0]      lanes;
	logic                  mem_write;
	logic                  mem_read;
	logic [DATA_WIDTH-1:0] mem_rdata;
	logic [DATA_WIDTH-1:0] write_data;

	assign selected  = !i_chip_select_low_1_n && !i_chip_select_low_2_n
		&& i_chip_select_high;
	assign load      = !i_clock_gate_n && !i_advance_or_load;
	assign advance   = !i_clock_gate_n && i_advance_or_load && state.burst_live;
	assign next_beat = state.beat + BEAT_STEP;
	assign lanes     = ~i_byte_write_selects_n;
	assign load_addr = i_address_lines;
	assign write_data = i_data_lines;

	burst_address u_burst_address (
		.i_order (i_burst_order_select),
		.i_base  (state.base[BURST_BITS-1:0]),
		.i_beat  (next_beat),
		.o_low   (beat_low)
	);

	always_comb begin
		beat_addr = state.base;
		beat_addr[BURST_BITS-1:0] = beat_low;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Array, accessed at the data cycle so write data come off the pins

	// Reads and writes both use the array at the data cycle, so a read right
	// behind a write to the same word sees the new data and one address serves
	assign mem_write = !i_clock_gate_n && state.stage2_kind == ACC_WRITE;
	assign mem_read  = !i_clock_gate_n && state.stage2_kind == ACC_READ;

	sram_array #(
		.ADDR_WIDTH (ADDR_WIDTH),
		.LANES      (LANES),
		.LANE_WIDTH (LANE_WIDTH)
	) u_sram_array (
		.i_clock      (i_clock),
		.i_read       (mem_read),
		.i_write      (mem_write),
		.i_address    (state.stage2_addr),
		.i_lane_write (state.stage2_lanes),
		.i_write_data (write_data),
		.o_read_data  (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_state = state;
		if (!i_clock_gate_n) begin
			next_state.stage1_kind  = ACC_IDLE;
			next_state.stage1_lanes = '0;
			if (load && selected) begin
				next_state.base        = load_addr;
				next_state.beat        = BEAT_FIRST;
				next_state.burst_live  = 1'b1;
				next_state.burst_kind  = i_read_not_write ? ACC_READ : ACC_WRITE;
				next_state.stage1_kind = next_state.burst_kind;
				next_state.stage1_addr = load_addr;
				next_state.stage1_lanes = i_read_not_write ? '0 : lanes;
			end else if (load) begin
				next_state.burst_live = 1'b0;
			end else if (advance) begin
				next_state.beat        = next_beat;
				next_state.burst_live  = next_beat != BEAT_LAST;
				next_state.stage1_kind = state.burst_kind;
				next_state.stage1_addr = beat_addr;
				next_state.stage1_lanes = state.burst_kind == ACC_WRITE ? lanes : '0;
			end
			// Pipeline keeps moving after deselect so pending data still transfer
			next_state.stage2_kind  = state.stage1_kind;
			next_state.stage2_addr  = state.stage1_addr;
			next_state.stage2_lanes = state.stage1_lanes;
			// Drive only in the read data cycle; floats for writes and deselects
			next_state.drive        = state.stage2_kind == ACC_READ;
		end
	end

	always_comb begin
		unique case (state.stage1_kind)
			ACC_IDLE, ACC_READ, ACC_WRITE: ;
			default: ;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= '{
				base:         '0,
				beat:         BEAT_FIRST,
				burst_live:   1'b0,
				burst_kind:   ACC_IDLE,
				stage1_kind:  ACC_IDLE,
				stage1_addr:  '0,
				stage1_lanes: '0,
				stage2_kind:  ACC_IDLE,
				stage2_addr:  '0,
				stage2_lanes: '0,
				drive:        1'b0
			};
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pins. The output enable gating is the one path not through a clock.

	// Array read register is the output register; not cleared by reset
	assign o_data_lines    = mem_rdata;
	assign o_data_lines_oe = state.drive && !i_output_drive_enable_n;
endmodule

//--- logic/sram_port_pkg.sv
// Shared constants for the pipelined zero-turnaround static memory port.
// Assumes a single rising-edge clock domain; no register bus.
package sram_port_pkg;
	localparam int ADDR_WIDTH_DEFAULT  = 18;
	localparam int LANES_DEFAULT       = 4;
	localparam int LANE_WIDTH_DEFAULT  = 9;
	localparam int BURST_BITS          = 2;
	localparam int PIPE_DEPTH          = 2;
	localparam logic [1:0] BEAT_FIRST  = 2'h0;
	localparam logic [1:0] BEAT_LAST   = 2'h3;
	localparam logic [1:0] BEAT_STEP   = 2'h1;
	localparam logic BURST_LINEAR      = 1'h0;
	localparam logic BURST_INTERLEAVED = 1'h1;

	typedef enum logic [2:0] {
		ACC_IDLE  = 3'h1,
		ACC_READ  = 3'h2,
		ACC_WRITE = 3'h4
	} access_type;
endpackage

//--- tb/sram_ctrl_model.sv
// Memory controller model driving the port pins one cycle per call.
// Assumes calls start 1 ns after a rising edge.
module sram_ctrl_model
	import sram_port_pkg::*;
(
	input  wire logic   i_clock,
	input  wire logic   i_rstn,
	output logic [17:0] o_address,
	output logic        o_advance,
	output logic        o_read,
	output logic        o_gate_n,
	output logic [3:0]  o_select_n,
	output logic [2:0]  o_chip,
	output logic        o_order,
	output logic [35:0] o_data
);
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [1:0]  kind;
		logic [17:0] a;
		logic [3:0]  bw;
		logic [35:0] d;
	} op_type;
	op_type      cur, p1, p2, p3;
	logic [17:0] base;
	logic [2:0]  beat;
	logic        live, rd;
	logic [35:0] last, salt;
	initial {o_address, o_advance, o_read, o_gate_n, o_select_n, o_chip, o_order} = '0;
	initial {cur, last, salt, live} = '0;
	// Released bus shows the inverse of the last word, never a stale copy
	assign o_data = (p2.kind == 2'h2) ? p2.d : ~last;
	always @(posedge i_clock) begin
		if (!i_rstn) begin
			{p1, p2, p3} <= '0;
		end else if (!o_gate_n) begin
			{p1, p2, p3} <= {cur, p1, p2};
			if (p2.kind == 2'h2) last <= p2.d;
		end
	end
	task automatic go(input logic ld, rw, input logic [2:0] cs, input logic [17:0] a,
		input logic [3:0] bw);
		{o_advance, o_read, o_chip, o_address, o_select_n, o_gate_n} = {!ld, rw, cs, a, bw, 1'h0};
		cur = '0;
		if (ld) begin
			{live, base, beat, rd} = {cs == 3'h1, a, 3'h0, rw};
		end else if (live) begin
			beat = beat + 3'h1;
			live = beat < 3'h4;
		end
		if (live) begin
			cur.kind = rd ? 2'h1 : 2'h2;
			cur.a = {base[17:2], o_order ? base[1:0] ^ beat[1:0] : base[1:0] + beat[1:0]};
			cur.bw = bw;
			cur.d = {cur.a, ~cur.a} ^ salt;
		end
		@(posedge i_clock);
		#1;
	endtask
	task automatic hold();
		{o_gate_n, o_advance, o_chip} = {1'h1, 1'h0, 3'h3};
		@(posedge i_clock);
		#1;
	endtask
endmodule

//--- tb/sram_port_monitor.sv
// Pin-level checker for the static memory port.
// Assumes one clock domain; bound to the port from the bench top.
module sram_port_monitor
	import sram_port_pkg::*;
#(
	parameter int LANES      = LANES_DEFAULT,
	parameter int LANE_WIDTH = LANE_WIDTH_DEFAULT
) (
	input wire logic                        i_clock,
	input wire logic                        i_rstn,
	input wire logic                        i_advance_or_load,
	input wire logic                        i_read_not_write,
	input wire logic                        i_clock_gate_n,
	input wire logic                        i_chip_select_low_1_n,
	input wire logic                        i_chip_select_low_2_n,
	input wire logic                        i_chip_select_high,
	input wire logic                        i_output_drive_enable_n,
	input wire logic [LANES*LANE_WIDTH-1:0] o_data_lines,
	input wire logic                        o_data_lines_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic run;
	logic sel;
	assign run = !i_clock_gate_n;
	assign sel = !i_chip_select_low_1_n && !i_chip_select_low_2_n && i_chip_select_high;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
////////////////////////////////////////////////////////////////////////////////
	sequence s_rd; run && !i_advance_or_load && sel && i_read_not_write; endsequence
	sequence s_wr; run && !i_advance_or_load && sel && !i_read_not_write; endsequence
	sequence s_off; run && !i_advance_or_load && !sel; endsequence
	sequence s_adv; run && i_advance_or_load; endsequence
	sequence s_flow; run [*2]; endsequence
	property p_async; i_output_drive_enable_n |-> !o_data_lines_oe; endproperty
	property p_read; s_rd ##1 s_flow |=> o_data_lines_oe || i_output_drive_enable_n; endproperty
	property p_float; s_off ##1 s_flow |=> !o_data_lines_oe; endproperty
	property p_turn; s_wr ##1 s_flow |=> !o_data_lines_oe; endproperty
	property p_pend; s_rd ##1 s_off ##1 run |=> o_data_lines_oe || i_output_drive_enable_n;
	endproperty
	property p_beat4; s_rd ##1 s_adv [*3] ##1 s_flow |=> o_data_lines_oe; endproperty
	property p_ended; s_off ##1 s_adv ##1 s_flow |=> !o_data_lines_oe; endproperty
	property p_hold;
		i_clock_gate_n |=> $stable(o_data_lines)
			&& ($stable(o_data_lines_oe) || !$stable(i_output_drive_enable_n));
	endproperty
	a_async: assert property (p_async) else $error("drive while output enable high");
	a_read: assert property (p_read) else $error("read data not driven");
	a_float: assert property (p_float) else $error("bus not floated after deselect");
	a_turn: assert property (p_turn) else $error("bus not released for write");
	a_pend: assert property (p_pend) else $error("pending read dropped");
	a_beat4: assert property (p_beat4) else $error("fourth beat missing");
	a_ended: assert property (p_ended) else $error("advance after deselect read");
	a_hold: assert property (p_hold) else $error("outputs moved on gated edge");
endmodule

//--- tb/sram_port_test.sv
// Self-checking bench for the static memory port.
// Assumes the controller model drives every pin but clock, reset and output enable.
module sram_port_test
	import sram_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        i_clock = 1'h0, i_rstn = 1'h0, oe_n = 1'h0;
	logic [17:0] address;
	logic        adv, rnw, gate_n, order, oe;
	logic [3:0]  bw_n;
	logic [2:0]  chip;
	logic [35:0] wr_data, rd_data;
	logic [35:0] mem [logic [17:0]];
	logic [2:0]  bad [3] = '{3'h5, 3'h3, 3'h0};
	int          errors = 0, num_checks = 0;
	always #2.5 i_clock = ~i_clock;
	sram_ctrl_model ctl_u (.i_clock(i_clock), .i_rstn(i_rstn), .o_address(address),
		.o_advance(adv), .o_read(rnw), .o_gate_n(gate_n), .o_select_n(bw_n), .o_chip(chip),
		.o_order(order), .o_data(wr_data));
	sram_port dut_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_address_lines(address),
		.i_advance_or_load(adv), .i_read_not_write(rnw), .i_clock_gate_n(gate_n),
		.i_byte_write_selects_n(bw_n), .i_chip_select_low_1_n(chip[2]),
		.i_chip_select_low_2_n(chip[1]), .i_chip_select_high(chip[0]),
		.i_burst_order_select(order), .i_output_drive_enable_n(oe_n), .i_data_lines(wr_data),
		.o_data_lines(rd_data), .o_data_lines_oe(oe));
////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [35:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Read check before commit: a read one cycle ahead must see old data
	always @(posedge i_clock) begin
		if (i_rstn && !gate_n && !oe_n) begin
			check("drive", oe, ctl_u.p3.kind == 2'h1);
			if (ctl_u.p3.kind == 2'h1) check("data", rd_data, mem[ctl_u.p3.a]);
		end
		if (i_rstn && !gate_n && ctl_u.p2.kind == 2'h2) begin
			for (int l = 0; l < 4; l++) begin
				if (!ctl_u.p2.bw[l]) mem[ctl_u.p2.a][l*9 +: 9] = ctl_u.p2.d[l*9 +: 9];
			end
		end
	end
	task automatic burst(input logic rw, input logic [17:0] a, input logic [3:0] bw, stall);
		ctl_u.go(1'h1, rw, 3'h1, a, bw);
		for (int k = 0; k < 3; k++) begin
			if (stall && k == 1) ctl_u.hold();
			ctl_u.go(1'h0, rw, 3'h1, ~a, bw);
		end
	endtask
	task automatic phase(input logic ord);
		i_rstn = 1'h0;
		ctl_u.o_order = ord;
		repeat (16) @(posedge i_clock);
		#1;
		i_rstn = 1'h1;
		ctl_u.salt = '0;
		burst(1'h0, 18'h00011, 4'h0, 1'h1);
		ctl_u.salt = '1;
		burst(1'h0, 18'h00011, 4'h5, 1'h0);
		burst(1'h1, 18'h00011, 4'h0, 1'h0);
		ctl_u.go(1'h0, 1'h1, 3'h1, 18'h00000, 4'h0);
		for (int i = 0; i < 3; i++) begin
			ctl_u.go(1'h1, 1'h1, 3'h1, 18'h00012, 4'h0);
			ctl_u.go(1'h1, 1'h1, bad[i], 18'h00013, 4'h0);
			ctl_u.go(1'h0, 1'h1, 3'h1, 18'h00013, 4'h0);
		end
		burst(1'h1, 18'h00013, 4'h0, 1'h0);
		oe_n = 1'h1;
		#1;
		check("float", oe, 1'h0);
		ctl_u.go(1'h1, 1'h1, 3'h0, 18'h00000, 4'h0);
		oe_n = 1'h0;
		repeat (3) ctl_u.go(1'h1, 1'h1, 3'h0, 18'h00000, 4'h0);
	endtask
	initial begin
		phase(BURST_LINEAR);
		phase(BURST_INTERLEAVED);
		end_sim();
	end
	initial begin
		#20000;
		errors++;
		end_sim();
	end
endmodule
bind sram_port sram_port_monitor #(.LANES(LANES), .LANE_WIDTH(LANE_WIDTH)) mon_u (
	.i_clock(i_clock), .i_rstn(i_rstn), .i_advance_or_load(i_advance_or_load),
	.i_read_not_write(i_read_not_write), .i_clock_gate_n(i_clock_gate_n),
	.i_chip_select_low_1_n(i_chip_select_low_1_n), .i_chip_select_low_2_n(i_chip_select_low_2_n),
	.i_chip_select_high(i_chip_select_high), .i_output_drive_enable_n(i_output_drive_enable_n),
	.o_data_lines(o_data_lines), .o_data_lines_oe(o_data_lines_oe));
